// >>> gxp_bus_master.sv
// Purpose: Serial-bus master model facing the expander
// Assumes: Half phase of eight system clocks
// Notes: Open-drain wire, pull-up wins unless pulled low
`timescale 1ns/10ps
`default_nettype none
module gxp_bus_master
(
	input wire logic clk_sys,
	input wire logic sdaOe,
	output gxp_pkg::gxp_bus_in_t busIn
);
	import gxp_pkg::*;
	logic sclR = 1'b1;
	logic sdaR = 1'b1;
	assign busIn = '{sclIn: sclR, sdaIn: sdaR & ~sdaOe};
	task automatic half();
		repeat (8) @(negedge clk_sys);
	endtask
	// Data moves only mid-low, so no false start or stop
	task automatic clockBit(input logic b, output logic s);
		half();
		sdaR = b;
		half();
		sclR = 1'b1;
		half();
		s = busIn.sdaIn;
		sclR = 1'b0;
	endtask
	task automatic start();
		sdaR = 1'b1;
		half();
		sclR = 1'b1;
		half();
		sdaR = 1'b0;
		half();
		sclR = 1'b0;
	endtask
	task automatic stop();
		half();
		sdaR = 1'b0;
		half();
		sclR = 1'b1;
		half();
		sdaR = 1'b1;
		half();
	endtask
	// Ninth bit: master level in, acknowledge out
	task automatic xferByte(input logic [7:0] tx, input logic ackBit, output logic [7:0] rx,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			clockBit(tx[i], s);
			rx[i] = s;
		end
		clockBit(ackBit, s);
		ack = ~s;
	endtask
endmodule
`default_nettype wire

// >>> gxp_expander.sv
// Purpose: Serial-bus slave with 16 general purpose pins in two banks
// Assumes: clk_sys much faster than the bus clock (at least 16x)
// Notes: All pins pass three flip-flops; a change counts when stages 2 and 3 agree
//
// Contract
// - Address 0100 00 plus strap bit
// - Address LSB: 1 read, 0 write
// - First write byte loads the pointer
// - Pointer bits 2:0 pick register
// - Pointer never returned on reads
// - Reads reuse last pointer until new command
// - Input registers show live pin levels
// - Writes to input registers ignored
// - Output bits drive outputs only; reset ones
// - Output register reads return written value
// - Invert bit flips sampled level; reset zero
// - Direction one is input; reset ones
// - Output pins driven, input pins floating
// - Reset loads defaults, bus machine idle
// - Multi-byte transfers alternate within pair
// - Input pin edge asserts interrupt low
// - Interrupt clears on revert or read ack
// - Reset pin low holds default state
`timescale 1ns/10ps
`default_nettype none
module gxp_expander
	import gxp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic resetPinN,
	input wire logic addrStrap,
	input wire gxp_pkg::gxp_bus_in_t busIn,
	output logic sdaOe,
	input wire gxp_pkg::gxp_port_t pinIn,
	output gxp_pkg::gxp_port_t pinOut,
	output gxp_pkg::gxp_port_t pinOe,
	output logic intOe
);
	import gxp_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK,
		ST_RD_BYTE, ST_RD_ACK} gxp_state_t;

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [SYNC_STAGES-1:0] sclSync_r, sdaSync_r, rstSync_r, strapSync_r;
	logic [15:0] pinS1_r, pinS2_r, pinS3_r;
	logic scl_r, sda_r, rstPinN_r, strap_r;
	logic [15:0] pinLevel_r;
	always_ff @(posedge clk_sys)
	begin
		sclSync_r <= {sclSync_r[1:0], busIn.sclIn};
		sdaSync_r <= {sdaSync_r[1:0], busIn.sdaIn};
		rstSync_r <= {rstSync_r[1:0], resetPinN};
		// Strap is a pin as well; same filter as the rest
		strapSync_r <= {strapSync_r[1:0], addrStrap};
		pinS1_r <= pinIn;
		pinS2_r <= pinS1_r;
		pinS3_r <= pinS2_r;
		if (sys_rst)
		begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			rstPinN_r <= 1'b1;
			strap_r <= 1'b0;
			pinLevel_r <= 16'h0000;
		end
		else
		begin
			// Change counts only when last two stages agree
			if (sclSync_r[1] == sclSync_r[2])
				scl_r <= sclSync_r[2];
			if (sdaSync_r[1] == sdaSync_r[2])
				sda_r <= sdaSync_r[2];
			if (rstSync_r[1] == rstSync_r[2])
				rstPinN_r <= rstSync_r[2];
			if (strapSync_r[1] == strapSync_r[2])
				strap_r <= strapSync_r[2];
			for (int i = 0; i < 16; i++)
				if (pinS2_r[i] == pinS3_r[i])
					pinLevel_r[i] <= pinS3_r[i];
		end
	end

	logic rst;
	assign rst = sys_rst || !rstPinN_r;

	logic sclPrev_r, sdaPrev_r;
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
		end
		else
		begin
			sclPrev_r <= scl_r;
			sdaPrev_r <= sda_r;
		end
	end
	logic sclRise, sclFall, startCond, stopCond;
	assign sclRise = scl_r && !sclPrev_r;
	assign sclFall = !scl_r && sclPrev_r;
	assign startCond = scl_r && sclPrev_r && sdaPrev_r && !sda_r;
	assign stopCond = scl_r && sclPrev_r && !sdaPrev_r && sda_r;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] drive0_r, drive1_r, invert0_r, invert1_r, dir0_r, dir1_r;
	logic [2:0] pointer_r;
	logic [15:0] sampled;
	// Inversion acts on the sampled value only
	assign sampled = pinLevel_r ^ {invert1_r, invert0_r};

	function automatic logic [7:0] readReg(input logic [2:0] idx, input logic [15:0] smp,
		input logic [47:0] rw);
		case (idx)
			REG_PIN_LEVEL_PORT0: readReg = smp[7:0];
			REG_PIN_LEVEL_PORT1: readReg = smp[15:8];
			REG_DRIVE_LEVEL_PORT0: readReg = rw[7:0];
			REG_DRIVE_LEVEL_PORT1: readReg = rw[15:8];
			REG_INVERT_PORT0: readReg = rw[23:16];
			REG_INVERT_PORT1: readReg = rw[31:24];
			REG_DIRECTION_PORT0: readReg = rw[39:32];
			default: readReg = rw[47:40];
		endcase
	endfunction

	logic [7:0] rdByte;
	assign rdByte = readReg(pointer_r, sampled,
		{dir1_r, dir0_r, invert1_r, invert0_r, drive1_r, drive0_r});

	// ----------------------------------------
	// Bus state machine
	// ----------------------------------------
	gxp_state_t state_r;
	logic [7:0] shift_r;
	logic [3:0] bitCnt_r;
	logic cmdPending_r, sdaLow_r, masterAck_r;
	logic wrStrobe, rdAckTaken;
	logic [7:0] rxByte;
	assign rxByte = shift_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			shift_r <= 8'h00;
			bitCnt_r <= 4'h0;
			cmdPending_r <= 1'b0;
			sdaLow_r <= 1'b0;
			masterAck_r <= 1'b0;
			pointer_r <= REG_PIN_LEVEL_PORT0;
		end
		else if (startCond)
		begin
			state_r <= ST_ADDR;
			bitCnt_r <= 4'h0;
			sdaLow_r <= 1'b0;
		end
		else if (stopCond)
		begin
			state_r <= ST_IDLE;
			sdaLow_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
					sdaLow_r <= 1'b0;
				ST_ADDR:
				begin
					if (sclRise)
					begin
						shift_r <= {shift_r[6:0], sda_r};
						bitCnt_r <= bitCnt_r + 4'h1;
					end
					if (sclFall && bitCnt_r == 4'h8)
					begin
						if (shift_r[7:1] == {ADDR_FIXED_BITS, strap_r})
						begin
							sdaLow_r <= 1'b1;
							state_r <= ST_ADDR_ACK;
							cmdPending_r <= !shift_r[0];
						end
						else
							state_r <= ST_IDLE;
					end
				end
				ST_ADDR_ACK, ST_WR_ACK:
					if (sclFall)
					begin
						bitCnt_r <= 4'h0;
						if (shift_r[0] && state_r == ST_ADDR_ACK)
						begin
							state_r <= ST_RD_BYTE;
							shift_r <= rdByte;
							sdaLow_r <= !rdByte[7];
						end
						else
						begin
							state_r <= ST_WR_BYTE;
							sdaLow_r <= 1'b0;
						end
					end
				ST_WR_BYTE:
				begin
					if (sclRise)
					begin
						shift_r <= {shift_r[6:0], sda_r};
						bitCnt_r <= bitCnt_r + 4'h1;
					end
					if (sclFall && bitCnt_r == 4'h8)
					begin
						sdaLow_r <= 1'b1;
						state_r <= ST_WR_ACK;
						if (cmdPending_r)
						begin
							pointer_r <= rxByte[2:0];
							cmdPending_r <= 1'b0;
						end
						else
							pointer_r <= pointer_r ^ 3'h1;
						// Keep bit 0 low so the ack path returns to writing
						shift_r[0] <= 1'b0;
					end
				end
				ST_RD_BYTE:
					if (sclFall)
					begin
						if (bitCnt_r == 4'h7)
						begin
							sdaLow_r <= 1'b0;
							state_r <= ST_RD_ACK;
							pointer_r <= pointer_r ^ 3'h1;
						end
						else
						begin
							shift_r <= {shift_r[6:0], 1'b0};
							sdaLow_r <= !shift_r[6];
							bitCnt_r <= bitCnt_r + 4'h1;
						end
					end
				ST_RD_ACK:
				begin
					if (sclRise)
						masterAck_r <= !sda_r;
					if (sclFall)
					begin
						bitCnt_r <= 4'h0;
						if (masterAck_r)
						begin
							state_r <= ST_RD_BYTE;
							shift_r <= rdByte;
							sdaLow_r <= !rdByte[7];
						end
						else
							state_r <= ST_IDLE;
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Pointer is only ever a selector; read data never includes it
	assign wrStrobe = (state_r == ST_WR_BYTE) && sclFall && bitCnt_r == 4'h8
		&& !cmdPending_r && !startCond && !stopCond;
	assign rdAckTaken = (state_r == ST_RD_ACK) && sclRise;
	assign sdaOe = sdaLow_r;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			drive0_r <= RST_DRIVE;
			drive1_r <= RST_DRIVE;
			invert0_r <= RST_INVERT;
			invert1_r <= RST_INVERT;
			dir0_r <= RST_DIRECTION;
			dir1_r <= RST_DIRECTION;
		end
		else if (wrStrobe)
		begin
			case (pointer_r)
				REG_DRIVE_LEVEL_PORT0: drive0_r <= rxByte;
				REG_DRIVE_LEVEL_PORT1: drive1_r <= rxByte;
				REG_INVERT_PORT0: invert0_r <= rxByte;
				REG_INVERT_PORT1: invert1_r <= rxByte;
				REG_DIRECTION_PORT0: dir0_r <= rxByte;
				REG_DIRECTION_PORT1: dir1_r <= rxByte;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pinOut <= {RST_DRIVE, RST_DRIVE};
			pinOe <= 16'h0000;
		end
		else
		begin
			pinOut <= {drive1_r, drive0_r};
			pinOe <= ~{dir1_r, dir0_r};
		end
	end

	// ----------------------------------------
	// Change interrupt
	// ----------------------------------------
	// Reference levels: a pin back at its reference clears its own request
	logic [15:0] refLevel_r;
	logic [15:0] changed;
	assign changed = (pinLevel_r ^ refLevel_r) & {dir1_r, dir0_r};
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			refLevel_r <= 16'h0000;
		else if (rdAckTaken && pointer_r[2:1] == 2'b00)
		begin
			// Pointer already toggled; the byte just sent is the other bank
			if (pointer_r[0])
				refLevel_r[7:0] <= pinLevel_r[7:0];
			else
				refLevel_r[15:8] <= pinLevel_r[15:8];
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			intOe <= 1'b0;
		else
			intOe <= |changed;
	end
endmodule
`default_nettype wire

// >>> gxp_expander_asserts.sv
// Purpose: Port-level checks for the expander
// Assumes: Each bus clock phase spans at least eight system clocks
// Notes: Sees only the top module ports
`timescale 1ns/10ps
`default_nettype none
module gxp_expander_asserts
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic resetPinN,
	input wire logic addrStrap,
	input wire gxp_pkg::gxp_bus_in_t busIn,
	input wire logic sdaOe,
	input wire gxp_pkg::gxp_port_t pinIn,
	input wire gxp_pkg::gxp_port_t pinOut,
	input wire gxp_pkg::gxp_port_t pinOe,
	input wire logic intOe
);
	import gxp_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	sequence sclHeld;
		busIn.sclIn [*3];
	endsequence
	// Pin passes a synchroniser, so give it six cycles
	sequence pinHeldLow;
		!resetPinN [*6];
	endsequence
	rst_pin_idle_a:
		assert property (sys_rst |=> pinOe == 16'h0000) else $error("pins driven after reset");
	rst_drive_ones_a:
		assert property (sys_rst |=> pinOut == 16'hFFFF) else $error("drive level not ones");
	rst_bus_idle_a:
		assert property (sys_rst |=> !sdaOe && !intOe) else $error("bus or flag active in reset");
	pin_rst_defaults_a:
		assert property (disable iff (sys_rst) pinHeldLow |-> pinOe == 16'h0000 && pinOut == 16'hFFFF)
		else $error("reset pin left pins active");
	pin_rst_bus_a:
		assert property (disable iff (sys_rst) pinHeldLow |-> !sdaOe && !intOe)
		else $error("reset pin left bus active");
	sda_steady_a:
		assert property (disable iff (sys_rst) sclHeld |-> $stable(sdaOe))
		else $error("data line moved while clock high");
	sda_rise_low_a:
		assert property (disable iff (sys_rst) $rose(sdaOe) |-> !busIn.sclIn ##1 !busIn.sclIn)
		else $error("data pulled outside clock low");
	pins_move_low_a:
		assert property (disable iff (sys_rst || !resetPinN)
			($changed(pinOe) || $changed(pinOut)) |-> !busIn.sclIn)
		else $error("pins changed outside a write");
endmodule
bind gxp_expander gxp_expander_asserts chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.resetPinN(resetPinN), .addrStrap(addrStrap), .busIn(busIn), .sdaOe(sdaOe),
	.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .intOe(intOe));
`default_nettype wire

// >>> gxp_expander_bench.sv
// Purpose: Self-checking bench for the port expander
// Assumes: Master model paces the bus
// Notes: Inputs move on falling clock edges
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin failCount++; \
	$display("BAD %0t %s", $time, m); end end
module gxp_expander_bench;
	import gxp_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic resetPinN = 1'b1;
	logic addrStrap = 1'b0;
	gxp_port_t pinIn = 16'h0000;
	gxp_bus_in_t busIn;
	logic sdaOe;
	gxp_port_t pinOut;
	gxp_port_t pinOe;
	logic intOe;
	int failCount = 0;
	int checked = 0;
	always #20 clk_sys = ~clk_sys;
	gxp_expander DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .resetPinN(resetPinN),
		.addrStrap(addrStrap), .busIn(busIn), .sdaOe(sdaOe), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .intOe(intOe));
	gxp_bus_master mst (.clk_sys(clk_sys), .sdaOe(sdaOe), .busIn(busIn));
	task automatic sendAddr(input logic rw);
		logic [7:0] r;
		logic a;
		mst.start();
		mst.xferByte({6'h10, addrStrap, rw}, 1'b1, r, a);
		`CHK(a, 1'b1, "address refused")
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
		logic [7:0] r;
		logic a;
		sendAddr(1'b0);
		mst.xferByte(cmd, 1'b1, r, a);
		mst.xferByte(d0, 1'b1, r, a);
		mst.xferByte(d1, 1'b1, r, a);
		mst.stop();
	endtask
	// Repeated start keeps the pointer; no cmd reuses it
	task automatic rd(input logic useCmd, input logic [7:0] cmd, input logic [7:0] e0,
		input logic [7:0] e1);
		logic [7:0] r;
		logic a;
		if (useCmd)
		begin
			sendAddr(1'b0);
			mst.xferByte(cmd, 1'b1, r, a);
		end
		sendAddr(1'b1);
		mst.xferByte(8'hFF, 1'b0, r, a);
		`CHK(r, e0, "first byte")
		mst.xferByte(8'hFF, 1'b1, r, a);
		`CHK(r, e1, "paired byte")
		mst.stop();
	endtask
	task automatic tDefaults();
		`CHK(pinOe, 16'h0000, "pins driven")
		`CHK(pinOut, 16'hFFFF, "drive level")
		rd(1'b1, 8'h02, 8'hFF, 8'hFF);
		rd(1'b1, 8'h05, 8'h00, 8'h00);
		rd(1'b1, 8'h07, 8'hFF, 8'hFF);
		$display("defaults done");
	endtask
	task automatic tDrive();
		wr(8'h03, 8'hA5, 8'h5A);
		wr(8'h06, 8'h00, 8'h0F);
		repeat (4) @(negedge clk_sys);
		`CHK(pinOe, 16'hF0FF, "direction")
		`CHK(pinOut & pinOe, 16'hA05A, "driven levels")
		rd(1'b1, 8'h02, 8'h5A, 8'hA5);
		$display("drive done");
	endtask
	task automatic tInvert();
		pinIn = 16'h3C96;
		wr(8'h04, 8'h0F, 8'hF0);
		rd(1'b1, 8'h00, 8'h99, 8'hCC);
		wr(8'h01, 8'h12, 8'h34);
		rd(1'b0, 8'h00, 8'hCC, 8'h99);
		`CHK(pinOe, 16'hF0FF, "state after input write")
		$display("invert done");
	endtask
	task automatic tStrap();
		logic [7:0] r;
		logic a;
		for (int s = 0; s < 2; s++)
		begin
			addrStrap = s[0];
			repeat (4) @(negedge clk_sys);
			mst.start();
			mst.xferByte({6'h10, ~addrStrap, 1'b0}, 1'b1, r, a);
			`CHK(a, 1'b0, "foreign address taken")
			mst.stop();
			rd(1'b1, 8'h06, 8'h00, 8'h0F);
		end
		$display("strap done");
	endtask
	task automatic waitInt(input logic e);
		repeat (12) @(negedge clk_sys);
		`CHK(intOe, e, "interrupt level")
	endtask
	task automatic tInterrupt();
		rd(1'b1, 8'h00, 8'h99, 8'hCC);
		waitInt(1'b0);
		pinIn[0] = 1'b1; // Output pin: must stay silent
		waitInt(1'b0);
		pinIn[0] = 1'b0;
		pinIn[8] = 1'b1;
		waitInt(1'b1);
		pinIn[8] = 1'b0;
		waitInt(1'b0);
		pinIn[9] = 1'b1;
		waitInt(1'b1);
		rd(1'b1, 8'h01, 8'hCE, 8'h99);
		waitInt(1'b0);
		$display("interrupt done");
	endtask
	task automatic tResetPin();
		resetPinN = 1'b0;
		repeat (8) @(negedge clk_sys);
		`CHK(pinOe, 16'h0000, "pins after pin reset")
		`CHK(pinOut, 16'hFFFF, "drive after pin reset")
		resetPinN = 1'b1;
		repeat (8) @(negedge clk_sys);
		rd(1'b1, 8'h06, 8'hFF, 8'hFF);
		rd(1'b1, 8'h02, 8'hFF, 8'hFF);
		$display("reset pin done");
	endtask
	task automatic summarize();
		$display("checked %0d failCount %0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		tDefaults();
		tDrive();
		tInvert();
		tStrap();
		tInterrupt();
		tResetPin();
		summarize();
	end
	// Whole run needs about 18000 cycles
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		failCount++;
		$display("BAD %0t watchdog expired", $time);
		summarize();
	end
endmodule
`default_nettype wire

// >>> gxp_pkg.sv
// Purpose: Shared constants and types for the 16-bit serial-bus port expander
// Assumes: Eight byte registers at command codes 0 to 7
// Notes: Pin groups travel as packed structs
package gxp_pkg;
	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [2:0] REG_PIN_LEVEL_PORT0 = 3'h0;
	localparam logic [2:0] REG_PIN_LEVEL_PORT1 = 3'h1;
	localparam logic [2:0] REG_DRIVE_LEVEL_PORT0 = 3'h2;
	localparam logic [2:0] REG_DRIVE_LEVEL_PORT1 = 3'h3;
	localparam logic [2:0] REG_INVERT_PORT0 = 3'h4;
	localparam logic [2:0] REG_INVERT_PORT1 = 3'h5;
	localparam logic [2:0] REG_DIRECTION_PORT0 = 3'h6;
	localparam logic [2:0] REG_DIRECTION_PORT1 = 3'h7;
	// ----------------------------------------
	// Reset values and address
	// ----------------------------------------
	localparam logic [7:0] RST_DRIVE = 8'hFF;
	localparam logic [7:0] RST_INVERT = 8'h00;
	localparam logic [7:0] RST_DIRECTION = 8'hFF;
	localparam logic [5:0] ADDR_FIXED_BITS = 6'h10;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic [7:0] highBank;
		logic [7:0] lowBank;
	} gxp_port_t;

	typedef struct packed {
		logic sclIn;
		logic sdaIn;
	} gxp_bus_in_t;
endpackage
